// ### hdl/rfb_map.svh
`ifndef RFB_MAP_SVH
`define RFB_MAP_SVH

// Register byte offsets on the Avalon-MM slave.
`define RFB_OFS_CTRL       5'h00
`define RFB_OFS_STATUS     5'h04
`define RFB_OFS_ALMOST_FULL_FLAG_THR  5'h08
`define RFB_OFS_ALMOST_EMPTY_FLAG_THR 5'h0c
`define RFB_OFS_INT_STATUS 5'h10
`define RFB_OFS_INT_MASK   5'h14

// Control register field positions.
`define RFB_CTRL_FIFO      0
`define RFB_CTRL_PIPE      1
`define RFB_CTRL_TWO_PORT  2
`define RFB_CTRL_FLUSH     3
`define RFB_CTRL_WW_LSB    4
`define RFB_CTRL_RW_LSB    8

// Interrupt status and mask bit positions.
`define RFB_INT_OVERFLOW   0
`define RFB_INT_UNDERFLOW  1
`define RFB_INT_ALMOST_FULL_FLAG      2
`define RFB_INT_ALMOST_EMPTY_FLAG     3

// Width select codes: 4k x 1, 2k x 2, 1k x 4, 512 x 9, 256 x 18.
`define RFB_WS_1           3'h0
`define RFB_WS_2           3'h1
`define RFB_WS_4           3'h2
`define RFB_WS_9           3'h3
`define RFB_WS_18          3'h4

// Reset values.
`define RFB_WS_RST         3'h3
`define RFB_TWO_PORT_RST   1'h1
`define RFB_ALMOST_FULL_FLAG_RST      13'h0e00
`define RFB_ALMOST_EMPTY_FLAG_RST     13'h0200

// FIFO capacity in eighths of a nine-bit word, and port clock ceiling.
`define RFB_CAP_EIGHTHS    14'h1000
`define RFB_PORT_FMAX_MHZ  350

`endif

// ### hdl/rfb_pkg.sv
package rfb_pkg;

  typedef logic [2:0]  rfb_ws_type;
  typedef logic [12:0] rfb_ptr_type;
  typedef logic [7:0]  rfb_row_type;
  typedef logic [4:0]  rfb_lsb_type;
  typedef logic [17:0] rfb_word_type;

endpackage

// ### hdl/rfb_mem.sv
`timescale 1ns/1ps

module rfb_mem #(
  parameter int ROWS = 256,
  parameter int DW   = 18
) (
  input  wire logic                    clk_sys,
  input  wire logic                    wr_en,
  input  wire logic [$clog2(ROWS)-1:0] wr_row,
  input  wire logic [DW-1:0]           wr_data,
  input  wire logic [DW-1:0]           wr_mask,
  input  wire logic                    rd_en,
  input  wire logic [$clog2(ROWS)-1:0] rd_row,
  output logic      [DW-1:0]           rd_data
);

  logic [DW-1:0] mem [ROWS];
  logic [DW-1:0] rd_data_q;

  assign rd_data = rd_data_q;

  // Bit mask lets a narrow write touch only its own slice of the row.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_data & wr_mask);
    end
    if (rd_en) begin
      rd_data_q <= mem[rd_row];
    end
  end

endmodule

// ### hdl/rfb_top.sv
`timescale 1ns/1ps
`include "rfb_map.svh"

module rfb_top
  import rfb_pkg::*;
#(
  parameter int ROWS = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        wr_clk_en,
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_addr,
  input  wire logic [17:0] wr_data,
  input  wire logic        rd_clk_en,
  input  wire logic        rd_en,
  input  wire logic [11:0] rd_addr,
  output logic      [17:0] rd_data,
  output logic             rd_valid,
  output logic             full_flag,
  output logic             empty_flag,
  output logic             almost_full_flag,
  output logic             almost_empty_flag,
  output logic             irq
);

  function automatic rfb_ws_type legal_ws(input logic [2:0] s, input logic two_port);
    rfb_ws_type r;
    r = s;
    if (s > `RFB_WS_18) begin
      r = `RFB_WS_9;
    end else if (s == `RFB_WS_18 && !two_port) begin
      r = `RFB_WS_9;
    end
    return r;
  endfunction

  function automatic logic [13:0] step_of(input rfb_ws_type ws);
    return (ws == `RFB_WS_18) ? 14'h0010 : 14'(14'h0001 << ws);
  endfunction

  function automatic rfb_word_type mask_of(input rfb_ws_type ws);
    rfb_word_type m;
    unique case (ws)
      `RFB_WS_1:  m = 18'h00001;
      `RFB_WS_2:  m = 18'h00003;
      `RFB_WS_4:  m = 18'h0000f;
      `RFB_WS_9:  m = 18'h001ff;
      default:    m = 18'h3ffff;
    endcase
    return m;
  endfunction

  function automatic rfb_row_type row_of(input logic [11:0] a, input rfb_ws_type ws);
    logic [11:0] w9;
    w9 = (ws == `RFB_WS_18) ? 12'h000 : 12'(a >> (3'h3 - ws));
    return (ws == `RFB_WS_18) ? a[7:0] : w9[8:1];
  endfunction

  function automatic rfb_lsb_type lsb_of(input logic [11:0] a, input rfb_ws_type ws);
    logic [11:0] w9;
    logic [11:0] sl;
    w9 = 12'h000;
    sl = 12'h000;
    if (ws != `RFB_WS_18) begin
      w9 = 12'(a >> (3'h3 - ws));
      sl = 12'((a & 12'(12'h001 << (3'h3 - ws)) - 12'h001) << ws);
    end
    return w9[0] ? 5'(sl) + 5'h09 : 5'(sl);
  endfunction

  // Control and bus state.
  logic         wait_q, wait_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         fifo_q, fifo_d;
  logic         pipe_q, pipe_d;
  logic         two_q, two_d;
  rfb_ws_type   wws_q, wws_d;
  rfb_ws_type   rws_q, rws_d;
  rfb_ptr_type  afthr_q, afthr_d;
  rfb_ptr_type  aethr_q, aethr_d;
  logic [3:0]   ist_q, ist_d;
  logic [3:0]   imask_q, imask_d;
  logic         irq_q, irq_d;
  // FIFO controller state.
  rfb_ptr_type  wp_q, wp_d;
  rfb_ptr_type  rp_q, rp_d;
  rfb_ptr_type  lvl_q, lvl_d;
  logic         full_q, full_d;
  logic         empty_q, empty_d;
  logic         af_q, af_d;
  logic         ae_q, ae_d;
  // Read path state.
  logic         s1_q, s1_d;
  rfb_lsb_type  lsb1_q, lsb1_d;
  rfb_ws_type   ws1_q, ws1_d;
  rfb_word_type pipe_data_q, pipe_data_d;
  logic         pv_q, pv_d;
  rfb_word_type rd_q, rd_d;
  logic         rv_q, rv_d;

  logic         bus_wr;
  logic         flush;
  logic         wr_go;
  logic         rd_go;
  logic [11:0]  waddr;
  logic [11:0]  raddr;
  rfb_lsb_type  wlsb;
  rfb_word_type mem_rd;
  rfb_word_type slice;
  logic [3:0]   events;

  assign bus_wr = avs_write & ~wait_q;
  assign flush  = bus_wr & (avs_address == `RFB_OFS_CTRL) & avs_writedata[`RFB_CTRL_FLUSH];

  // FIFO controller and address multiplexing.
  always_comb begin
    wr_go = wr_clk_en & wr_en & (~fifo_q | ~full_q);
    rd_go = rd_clk_en & rd_en & (~fifo_q | ~empty_q);
    waddr = fifo_q ? 12'(wp_q[11:0] >> wws_q) : wr_addr;
    raddr = fifo_q ? 12'(rp_q[11:0] >> rws_q) : rd_addr;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (fifo_q && wr_go) begin
      wp_d = 13'(wp_q + step_of(wws_q));
    end
    if (fifo_q && rd_go) begin
      rp_d = 13'(rp_q + step_of(rws_q));
    end
    if (flush) begin
      wp_d = 13'h0000;
      rp_d = 13'h0000;
    end
    // One clock serves both ports, so the pointers meet without a crossing.
    lvl_d   = 13'(wp_d - rp_d);
    full_d  = ({1'b0, lvl_d} + step_of(wws_q)) > `RFB_CAP_EIGHTHS;
    empty_d = {1'b0, lvl_d} < step_of(rws_q);
    af_d    = lvl_d >= afthr_q;
    ae_d    = lvl_d <= aethr_q;
    events  = 4'h0;
    events[`RFB_INT_OVERFLOW]  = fifo_q & wr_clk_en & wr_en & full_q;
    events[`RFB_INT_UNDERFLOW] = fifo_q & rd_clk_en & rd_en & empty_q;
    events[`RFB_INT_ALMOST_FULL_FLAG]     = af_d & ~af_q;
    events[`RFB_INT_ALMOST_EMPTY_FLAG]    = ae_d & ~ae_q;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wp_q    <= 13'h0000;
      rp_q    <= 13'h0000;
      lvl_q   <= 13'h0000;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
      af_q    <= 1'b0;
      ae_q    <= 1'b1;
    end else begin
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      lvl_q   <= lvl_d;
      full_q  <= full_d;
      empty_q <= empty_d;
      af_q    <= af_d;
      ae_q    <= ae_d;
    end
  end

  // Writes place the data in its own slice; other bits of the row are kept.
  assign wlsb = lsb_of(waddr, wws_q);

  rfb_mem #(
    .ROWS (ROWS),
    .DW   (18)
  ) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (wr_go),
    .wr_row  (row_of(waddr, wws_q)),
    .wr_data (18'((wr_data & mask_of(wws_q)) << wlsb)),
    .wr_mask (18'(mask_of(wws_q) << wlsb)),
    .rd_en   (rd_go),
    .rd_row  (row_of(raddr, rws_q)),
    .rd_data (mem_rd)
  );

  // Read path: array register, optional pipeline register, output register.
  always_comb begin
    s1_d   = rd_go;
    lsb1_d = lsb_of(raddr, rws_q);
    ws1_d  = rws_q;
    slice  = 18'(mem_rd >> lsb1_q) & mask_of(ws1_q);
    pipe_data_d = pipe_data_q;
    pv_d   = 1'b0;
    rd_d   = rd_q;
    rv_d   = 1'b0;
    if (pipe_q) begin
      pv_d = s1_q;
      if (s1_q) begin
        pipe_data_d = slice;
      end
      if (pv_q) begin
        rd_d = pipe_data_q;
      end
      rv_d = pv_q;
    end else begin
      if (s1_q) begin
        rd_d = slice;
      end
      rv_d = s1_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_q        <= 1'b0;
      lsb1_q      <= 5'h00;
      ws1_q       <= `RFB_WS_RST;
      pipe_data_q <= 18'h00000;
      pv_q        <= 1'b0;
      rd_q        <= 18'h00000;
      rv_q        <= 1'b0;
    end else begin
      s1_q        <= s1_d;
      lsb1_q      <= lsb1_d;
      ws1_q       <= ws1_d;
      pipe_data_q <= pipe_data_d;
      pv_q        <= pv_d;
      rd_q        <= rd_d;
      rv_q        <= rv_d;
    end
  end

  // Avalon slave: each access waits one cycle, then completes with wait low.
  always_comb begin
    wait_d  = ~((avs_read | avs_write) & wait_q);
    rdata_d = rdata_q;
    fifo_d  = fifo_q;
    pipe_d  = pipe_q;
    two_d   = two_q;
    wws_d   = wws_q;
    rws_d   = rws_q;
    afthr_d = afthr_q;
    aethr_d = aethr_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (avs_read && wait_q) begin
      unique case (avs_address)
        `RFB_OFS_CTRL:       rdata_d = {21'h000000, rws_q, 1'b0, wws_q, 1'b0, two_q, pipe_q,
                                        fifo_q};
        `RFB_OFS_STATUS:     rdata_d = {3'h0, lvl_q, 12'h000, ae_q, af_q, empty_q, full_q};
        `RFB_OFS_ALMOST_FULL_FLAG_THR:  rdata_d = {19'h00000, afthr_q};
        `RFB_OFS_ALMOST_EMPTY_FLAG_THR: rdata_d = {19'h00000, aethr_q};
        `RFB_OFS_INT_STATUS: rdata_d = {28'h0000000, ist_q};
        `RFB_OFS_INT_MASK:   rdata_d = {28'h0000000, imask_q};
        default:             rdata_d = 32'h00000000;
      endcase
    end
    if (bus_wr) begin
      unique case (avs_address)
        `RFB_OFS_CTRL: begin
          fifo_d = avs_writedata[`RFB_CTRL_FIFO];
          pipe_d = avs_writedata[`RFB_CTRL_PIPE];
          two_d  = avs_writedata[`RFB_CTRL_TWO_PORT];
          wws_d  = legal_ws(avs_writedata[`RFB_CTRL_WW_LSB +: 3],
                            avs_writedata[`RFB_CTRL_TWO_PORT]);
          rws_d  = legal_ws(avs_writedata[`RFB_CTRL_RW_LSB +: 3],
                            avs_writedata[`RFB_CTRL_TWO_PORT]);
        end
        `RFB_OFS_ALMOST_FULL_FLAG_THR:  afthr_d = avs_writedata[12:0];
        `RFB_OFS_ALMOST_EMPTY_FLAG_THR: aethr_d = avs_writedata[12:0];
        `RFB_OFS_INT_STATUS: ist_d   = ist_q & ~avs_writedata[3:0];
        `RFB_OFS_INT_MASK:   imask_d = avs_writedata[3:0];
        default:             ist_d   = ist_q;
      endcase
    end
    // A new event in the clearing cycle survives the write of one.
    ist_d = ist_d | events;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      fifo_q  <= 1'b0;
      pipe_q  <= 1'b0;
      two_q   <= `RFB_TWO_PORT_RST;
      wws_q   <= `RFB_WS_RST;
      rws_q   <= `RFB_WS_RST;
      afthr_q <= `RFB_ALMOST_FULL_FLAG_RST;
      aethr_q <= `RFB_ALMOST_EMPTY_FLAG_RST;
      ist_q   <= 4'h0;
      imask_q <= 4'h0;
      irq_q   <= 1'b0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      fifo_q  <= fifo_d;
      pipe_q  <= pipe_d;
      two_q   <= two_d;
      wws_q   <= wws_d;
      rws_q   <= rws_d;
      afthr_q <= afthr_d;
      aethr_q <= aethr_d;
      ist_q   <= ist_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign rd_data           = rd_q;
  assign rd_valid          = rv_q;
  assign full_flag         = full_q;
  assign empty_flag        = empty_q;
  assign almost_full_flag  = af_q;
  assign almost_empty_flag = ae_q;
  assign irq               = irq_q;

endmodule

// ### verif/rfb_top_properties.sv
`timescale 1ns/1ps
`include "rfb_map.svh"

module rfb_top_properties
  import rfb_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        wr_clk_en,
  input wire logic        wr_en,
  input wire logic        rd_clk_en,
  input wire logic        rd_en,
  input wire logic        rd_valid,
  input wire logic        full_flag,
  input wire logic        empty_flag,
  input wire logic        almost_full_flag,
  input wire logic        almost_empty_flag,
  input wire logic        irq
);
  logic fifo_q, fifo_d, pipe_q, pipe_d;
  wire logic rd_take;
  assign rd_take = rd_clk_en && rd_en;

  // The mode is shadowed from completed control writes, since only the ports are visible.
  always_comb begin
    fifo_d = fifo_q;
    pipe_d = pipe_q;
    if (avs_write && !avs_waitrequest && avs_address == `RFB_OFS_CTRL) begin
      fifo_d = avs_writedata[`RFB_CTRL_FIFO];
      pipe_d = avs_writedata[`RFB_CTRL_PIPE];
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fifo_q <= 1'b0;
      pipe_q <= 1'b0;
    end else begin
      fifo_q <= fifo_d;
      pipe_q <= pipe_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  read_lat_a: assert property (rd_take && !pipe_q && !(fifo_q && empty_flag)
    |-> ##2 rd_valid)
    else $error("plain read latency wrong");
  pipe_lat_a: assert property (rd_take && pipe_q && !(fifo_q && empty_flag)
    |-> ##3 rd_valid)
    else $error("pipelined read latency wrong");
  valid_cause_a: assert property (rd_valid |-> $past(rd_take, 2) || $past(rd_take, 3))
    else $error("read data without a read");
  empty_refuse_a: assert property (rd_take && fifo_q && empty_flag && !pipe_q
    |-> ##2 !rd_valid)
    else $error("read taken while empty");
  full_hold_a: assert property (fifo_q && full_flag && wr_clk_en && wr_en && !rd_take
    && !avs_write |=> full_flag)
    else $error("write taken while full");
  ram_flags_a: assert property (!fifo_q && !avs_write && !$past(avs_write)
    |=> $stable({full_flag, empty_flag, almost_full_flag, almost_empty_flag}))
    else $error("flags moved in memory mode");
  flag_excl_a: assert property (full_flag |-> !empty_flag)
    else $error("full and empty together");

  cover property (fifo_q && full_flag);
  cover property (pipe_q && rd_valid);
  cover property (irq);
endmodule

// ### verif/rfb_fabric_model.sv
`timescale 1ns/1ps

module rfb_fabric_model
  import rfb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rd_valid,
  input  wire logic [17:0] rd_data,
  output logic             wr_clk_en,
  output logic             wr_en,
  output logic      [11:0] wr_addr,
  output logic      [17:0] wr_data,
  output logic             rd_clk_en,
  output logic             rd_en,
  output logic      [11:0] rd_addr
);
  initial begin
    wr_clk_en = 1'b1;
    wr_en = 1'b0;
    wr_addr = 12'h000;
    wr_data = 18'h00000;
    rd_clk_en = 1'b1;
    rd_en = 1'b0;
    rd_addr = 12'h000;
  end

  // A slow write waits one cycle with its port clock held off.
  task put(input logic [11:0] a, input logic [17:0] d, input logic slow);
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    wr_clk_en <= !slow;
    @(posedge clk_sys);
    if (slow) begin
      wr_clk_en <= 1'b1;
      @(posedge clk_sys);
    end
  endtask

  // Released data is inverted so a stale value can never pass for a fresh one.
  task idle_w();
    wr_en <= 1'b0;
    wr_data <= ~wr_data;
  endtask

  // The wait is bounded, so ok tells the bench whether an answer came at all.
  task get(input logic [11:0] a, output logic [17:0] q, output logic ok);
    int n;
    rd_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    for (n = 0; n < 6 && rd_valid !== 1'b1; n++)
      @(posedge clk_sys);
    ok = (rd_valid === 1'b1);
    q = rd_data;
  endtask
endmodule

// ### verif/dual_clock_ram_fifo_block_bench.sv
`timescale 1ns/1ps
`include "rfb_map.svh"

module dual_clock_ram_fifo_block_bench
  import rfb_pkg::*;
;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic        wr_clk_en, wr_en, rd_clk_en, rd_en, rd_valid, irq, ok;
  logic        full_flag, empty_flag, almost_full_flag, almost_empty_flag;
  logic [11:0] wr_addr, rd_addr;
  logic [17:0] wr_data, rd_data, q;
  int          errors, samples_checked, i;

  rfb_top dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wr_clk_en(wr_clk_en), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_clk_en(rd_clk_en), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .full_flag(full_flag), .empty_flag(empty_flag),
    .almost_full_flag(almost_full_flag), .almost_empty_flag(almost_empty_flag), .irq(irq));

  rfb_fabric_model fab (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_clk_en(wr_clk_en), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_clk_en(rd_clk_en), .rd_en(rd_en), .rd_addr(rd_addr));

  always #5 clk_sys = ~clk_sys;

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(`RFB_OFS_CTRL, 32'h0000_0334);
    rd(`RFB_OFS_STATUS, 32'h0000_000a);
    rd(`RFB_OFS_ALMOST_FULL_FLAG_THR, 32'h0000_0e00);
    rd(`RFB_OFS_ALMOST_EMPTY_FLAG_THR, 32'h0000_0200);
    av(1'b1, 5'h18, 32'hffff_ffff);
    rd(5'h18, 32'h0);
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_0040);
    rd(`RFB_OFS_CTRL, 32'h0000_0030);
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_044d);
    rd(`RFB_OFS_CTRL, 32'h0000_0445);
    fab.get(12'h000, q, ok);
    chk(32'(ok), 32'h0);
    rd(`RFB_OFS_INT_STATUS, 32'h0000_0002);
    av(1'b1, `RFB_OFS_INT_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    av(1'b1, `RFB_OFS_INT_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    // Addresses are junk on purpose: the controller must ignore them.
    for (i = 0; i < 256; i++)
      fab.put(12'hfff, 18'(i * 257), i == 3);
    fab.idle_w();
    repeat (2) @(posedge clk_sys);
    chk(32'({full_flag, almost_full_flag, empty_flag, almost_empty_flag}), 32'hc);
    rd(`RFB_OFS_STATUS, 32'h1000_0005);
    fab.put(12'h000, 18'h3ffff, 1'b0);
    fab.idle_w();
    rd(`RFB_OFS_INT_STATUS, 32'h0000_0005);
    chk(32'(irq), 32'h0);
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_0447);
    for (i = 0; i < 256; i++) begin
      fab.get(12'h000, q, ok);
      chk(32'(ok), 32'h1);
      chk(32'(q), 32'(18'(i * 257)));
    end
    rd(`RFB_OFS_STATUS, 32'h0000_000a);
    rd(`RFB_OFS_INT_STATUS, 32'h0000_000d);
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_0234);
    fab.put(12'h000, 18'h001a5, 1'b0);
    fab.idle_w();
    fab.get(12'h000, q, ok);
    chk(32'(q), 32'h5);
    fab.get(12'h001, q, ok);
    chk(32'(q), 32'ha);
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_0344);
    fab.put(12'h000, 18'h2d1b3, 1'b1);
    fab.idle_w();
    fab.get(12'h000, q, ok);
    chk(32'(q), 32'h1b3);
    fab.get(12'h001, q, ok);
    chk(32'(q), 32'h168);
    rd(`RFB_OFS_STATUS, 32'h0000_000a);
    // Single bits written, bit pairs read back through the pipelined read.
    av(1'b1, `RFB_OFS_CTRL, 32'h0000_0106);
    rd(`RFB_OFS_CTRL, 32'h0000_0106);
    for (i = 0; i < 4; i++)
      fab.put(12'(i), 18'(i != 1), 1'b0);
    fab.idle_w();
    fab.get(12'h000, q, ok);
    chk(32'(q), 32'h1);
    fab.get(12'h001, q, ok);
    chk(32'(ok), 32'h1);
    chk(32'(q), 32'h3);
    av(1'b1, `RFB_OFS_ALMOST_FULL_FLAG_THR, 32'hffff_ffff);
    rd(`RFB_OFS_ALMOST_FULL_FLAG_THR, 32'h0000_1fff);
    // A second reset restores the settings but leaves the array as it was.
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'(rd_data), 32'h0);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(`RFB_OFS_ALMOST_FULL_FLAG_THR, 32'h0000_0e00);
    rd(`RFB_OFS_CTRL, 32'h0000_0334);
    fab.get(12'h000, q, ok);
    chk(32'(ok), 32'h1);
    chk(32'(q), 32'h1bd);
    rd(`RFB_OFS_STATUS, 32'h0000_000a);
    stop_test();
  end
endmodule

bind rfb_top rfb_top_properties props (.clk_sys(clk_sys), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .wr_clk_en(wr_clk_en), .wr_en(wr_en), .rd_clk_en(rd_clk_en), .rd_en(rd_en),
  .rd_valid(rd_valid), .full_flag(full_flag), .empty_flag(empty_flag),
  .almost_full_flag(almost_full_flag), .almost_empty_flag(almost_empty_flag), .irq(irq));
